//--- rtl/gpb_top.sv
// gpio bank, ports A to H, with a classic wishbone register slave
// assumes a wishbone master on clk_sys and pads resolved outside
`timescale 1ns/1ns
`include "gpb_cfg.svh"

module gpb_top #(
    parameter logic [7:0]  EDGE_SEL_PORTS = `GPB_EDGE_SEL_PORTS,
    parameter logic [63:0] IMPL_MASK      = `GPB_IMPL_MASK
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         wb_cyc,
    input  wire logic         wb_stb,
    input  wire logic         wb_we,
    input  wire logic [31:0]  wb_adr,
    input  wire logic [3:0]   wb_sel,
    input  wire logic [31:0]  wb_dat_w,
    output      logic [31:0]  wb_dat_r,
    output      logic         wb_ack,
    output      logic         irq,
    input  wire logic [63:0]  pad_i,
    output      logic [63:0]  pad_o,
    output      logic [63:0]  pad_oe,
    input  wire logic [191:0] alt_o,
    input  wire logic [191:0] alt_oe,
    output      logic [63:0]  alt_in
);
    import gpb_pkg::*;

    localparam int NP = `GPB_NUM_PORTS;

    gpb_byte_t out_val   [NP];
    gpb_byte_t dir       [NP];
    gpb_byte_t odc       [NP];
    gpb_byte_t alt_select_high       [NP];
    gpb_byte_t alt_select_low       [NP];
    gpb_byte_t edge_rise [NP];
    gpb_byte_t int_stat  [NP];
    gpb_byte_t int_mask  [NP];
    gpb_byte_t level     [NP];
    gpb_byte_t evt       [NP];

    gpb_byte_t next_out_val   [NP];
    gpb_byte_t next_dir       [NP];
    gpb_byte_t next_odc       [NP];
    gpb_byte_t next_afh       [NP];
    gpb_byte_t next_afl       [NP];
    gpb_byte_t next_edge_rise [NP];
    gpb_byte_t next_int_stat  [NP];
    gpb_byte_t next_int_mask  [NP];

    logic        ack;
    logic [7:0]  rdata;
    logic        next_ack;
    logic [7:0]  next_rdata;
    logic        next_irq;
    logic        irq_q;
    logic        req;
    logic        wr;
    logic [2:0]  port;
    logic [5:0]  ofs;
    gpb_byte_t   wbyte;

    // a word offset inside the per-port block that holds a register
    function automatic logic gpb_ofs_valid(input logic [5:0] o);
        gpb_ofs_valid = (o[1:0] == 2'b00) && (o <= `GPB_OFS_MASK);
    endfunction

    // a bus address that lands on a register at all
    function automatic logic gpb_mapped(input logic [31:0] a);
        gpb_mapped = (a[31:9] == `GPB_ADR_TOP_ZERO) && gpb_ofs_valid(a[5:0]);
    endfunction

    // per-port pin logic
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_port
            gpb_port_if pif ();

            assign pif.out_val   = out_val[gp];
            assign pif.dir       = dir[gp];
            assign pif.odc       = odc[gp];
            assign pif.alt_select_high       = alt_select_high[gp];
            assign pif.alt_select_low       = alt_select_low[gp];
            assign pif.edge_rise = edge_rise[gp];
            assign level[gp]     = pif.level;
            assign evt[gp]       = pif.evt;

            gpb_port_pins #(
                .IMPL     (IMPL_MASK[gp*8 +: 8]),
                .EDGE_SEL (EDGE_SEL_PORTS[gp])
            ) u_pins (
                .clk_sys (clk_sys),
                .rst     (rst),
                .cfg     (pif.pins),
                .pad_i   (pad_i[gp*8 +: 8]),
                .pad_o   (pad_o[gp*8 +: 8]),
                .pad_oe  (pad_oe[gp*8 +: 8]),
                .alt_o   (alt_o[gp*24 +: 24]),
                .alt_oe  (alt_oe[gp*24 +: 24]),
                .alt_in  (alt_in[gp*8 +: 8])
            );
        end
    endgenerate

    assign req   = wb_cyc & wb_stb & ~ack;
    assign wr    = req & wb_we & wb_sel[0] & gpb_mapped(wb_adr);
    assign port  = wb_adr[8:6];
    assign ofs   = wb_adr[5:0];
    assign wbyte = wb_dat_w[7:0];

    // register file next state
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            next_out_val[p]   = out_val[p];
            next_dir[p]       = dir[p];
            next_odc[p]       = odc[p];
            next_afh[p]       = alt_select_high[p];
            next_afl[p]       = alt_select_low[p];
            next_edge_rise[p] = edge_rise[p];
            next_int_mask[p]  = int_mask[p];
            next_int_stat[p]  = int_stat[p];
        end
        if (wr) begin
            case (ofs)
                `GPB_OFS_OUT: begin
                    next_out_val[port] = wbyte & IMPL_MASK[port*8 +: 8];
                end
                `GPB_OFS_DIR: begin
                    next_dir[port] = wbyte | ~IMPL_MASK[port*8 +: 8];
                end
                `GPB_OFS_ODC: begin
                    next_odc[port] = wbyte & IMPL_MASK[port*8 +: 8];
                end
                `GPB_OFS_AFH: begin
                    next_afh[port] = wbyte & IMPL_MASK[port*8 +: 8];
                end
                `GPB_OFS_AFL: begin
                    next_afl[port] = wbyte & IMPL_MASK[port*8 +: 8];
                end
                `GPB_OFS_EDGE: begin
                    // only ports with edge choice keep this register
                    next_edge_rise[port] = EDGE_SEL_PORTS[port] ?
                                           (wbyte & IMPL_MASK[port*8 +: 8]) : `GPB_RST_CLR;
                end
                `GPB_OFS_STAT: begin
                    next_int_stat[port] = int_stat[port] & ~wbyte;
                end
                `GPB_OFS_MASK: begin
                    next_int_mask[port] = wbyte & IMPL_MASK[port*8 +: 8];
                end
                default: begin
                    // input register and holes: writes are acknowledged only
                end
            endcase
        end
        // an edge in the clearing cycle still sets its bit
        for (int p = 0; p < NP; p++) begin
            next_int_stat[p] = next_int_stat[p] | evt[p];
        end
    end

    // bus answer and interrupt line
    always_comb begin
        next_ack   = req;
        next_rdata = 8'h00;
        next_irq   = 1'b0;
        for (int p = 0; p < NP; p++) begin
            next_irq = next_irq | (|(next_int_stat[p] & next_int_mask[p]));
        end
        if (req && !wb_we && gpb_mapped(wb_adr)) begin
            case (ofs)
                `GPB_OFS_IN:   next_rdata = level[port];
                `GPB_OFS_OUT:  next_rdata = out_val[port];
                `GPB_OFS_DIR:  next_rdata = dir[port];
                `GPB_OFS_ODC:  next_rdata = odc[port];
                `GPB_OFS_AFH:  next_rdata = alt_select_high[port];
                `GPB_OFS_AFL:  next_rdata = alt_select_low[port];
                `GPB_OFS_EDGE: next_rdata = edge_rise[port];
                `GPB_OFS_STAT: next_rdata = int_stat[port];
                `GPB_OFS_MASK: next_rdata = int_mask[port];
                default:       next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int p = 0; p < NP; p++) begin
                out_val[p]   <= `GPB_RST_OUT;
                dir[p]       <= `GPB_RST_DIR;
                odc[p]       <= `GPB_RST_CLR;
                alt_select_high[p]       <= `GPB_RST_CLR;
                alt_select_low[p]       <= `GPB_RST_CLR;
                edge_rise[p] <= `GPB_RST_CLR;
                int_stat[p]  <= `GPB_RST_CLR;
                int_mask[p]  <= `GPB_RST_CLR;
            end
            ack   <= 1'b0;
            rdata <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                out_val[p]   <= next_out_val[p];
                dir[p]       <= next_dir[p];
                odc[p]       <= next_odc[p];
                alt_select_high[p]       <= next_afh[p];
                alt_select_low[p]       <= next_afl[p];
                edge_rise[p] <= next_edge_rise[p];
                int_stat[p]  <= next_int_stat[p];
                int_mask[p]  <= next_int_mask[p];
            end
            ack   <= next_ack;
            rdata <= next_rdata;
            irq_q <= next_irq;
        end
    end

    assign wb_ack   = ack;
    assign wb_dat_r = {24'h00_0000, rdata};
    assign irq      = irq_q;
endmodule

//--- rtl/gpb_cfg.svh
// gpio bank constants: register offsets, reset values, pin population
// assumes inclusion by bare name from every file that needs these numbers
`ifndef GPB_CFG_SVH
`define GPB_CFG_SVH

`define GPB_NUM_PORTS      8
`define GPB_PORT_SHIFT     6
`define GPB_ADR_TOP_ZERO   23'h00_0000

`define GPB_OFS_IN         6'h00
`define GPB_OFS_OUT        6'h04
`define GPB_OFS_DIR        6'h08
`define GPB_OFS_ODC        6'h0C
`define GPB_OFS_AFH        6'h10
`define GPB_OFS_AFL        6'h14
`define GPB_OFS_EDGE       6'h18
`define GPB_OFS_STAT       6'h1C
`define GPB_OFS_MASK       6'h20

`define GPB_RST_OUT        8'h00
`define GPB_RST_DIR        8'hFF
`define GPB_RST_CLR        8'h00

// ports A..E full, F and G pin 1 only, H pins 3..0; port A in the low byte
`define GPB_IMPL_MASK      64'h0F02_02FF_FFFF_FFFF
// ports A and C choose rising or falling per pin, the rest take any edge
`define GPB_EDGE_SEL_PORTS 8'h05
`define GPB_SYNC_FILL      2'h3

`endif

//--- rtl/gpb_pkg.sv
// gpio bank shared types
// assumes nothing beyond a SystemVerilog compiler
package gpb_pkg;
    typedef logic [7:0] gpb_byte_t;

    typedef enum logic [1:0] {
        GPB_ALT_NONE = 2'b00,
        GPB_ALT_FN1  = 2'b01,
        GPB_ALT_FN2  = 2'b10,
        GPB_ALT_FN3  = 2'b11
    } gpb_alt_e;
endpackage

//--- rtl/gpb_port_if.sv
// configuration and status carried between the register file and one port
// assumes one instance per port, all on clk_sys
`timescale 1ns/1ns
interface gpb_port_if;
    import gpb_pkg::*;
    gpb_byte_t out_val;
    gpb_byte_t dir;
    gpb_byte_t odc;
    gpb_byte_t alt_select_high;
    gpb_byte_t alt_select_low;
    gpb_byte_t edge_rise;
    gpb_byte_t level;
    gpb_byte_t evt;

    modport regs (output out_val, output dir, output odc, output alt_select_high, output alt_select_low,
                  output edge_rise, input level, input evt);
    modport pins (input out_val, input dir, input odc, input alt_select_high, input alt_select_low,
                  input edge_rise, output level, output evt);
endinterface

//--- rtl/gpb_port_pins.sv
// pin logic of one eight-bit port: synchroniser, edge events, drive muxing
// assumes pads and peripheral alternate signals arrive unsynchronised
`timescale 1ns/1ns
`include "gpb_cfg.svh"
module gpb_port_pins #(
    parameter logic [7:0] IMPL     = 8'hFF,
    parameter logic       EDGE_SEL = 1'b0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    gpb_port_if.pins         cfg,
    input  wire logic [7:0]  pad_i,
    output      logic [7:0]  pad_o,
    output      logic [7:0]  pad_oe,
    input  wire logic [23:0] alt_o,
    input  wire logic [23:0] alt_oe,
    output      logic [7:0]  alt_in
);
    import gpb_pkg::*;

    gpb_byte_t sync1;
    gpb_byte_t sync2;
    gpb_byte_t prev;
    logic [1:0] fill;
    gpb_byte_t drv_o;
    gpb_byte_t drv_oe;
    gpb_byte_t next_sync1;
    gpb_byte_t next_sync2;
    gpb_byte_t next_prev;
    logic [1:0] next_fill;
    gpb_byte_t next_drv_o;
    gpb_byte_t next_drv_oe;
    gpb_byte_t rise;
    gpb_byte_t fall;
    gpb_alt_e  fsel;
    logic      en;
    logic      val;

    always_comb begin
        next_sync1 = pad_i;
        next_sync2 = sync1;
        next_prev  = sync2;
        next_fill  = (fill == `GPB_SYNC_FILL) ? fill : fill + 2'h1;
        rise = sync2 & ~prev;
        fall = ~sync2 & prev;
        for (int b = 0; b < 8; b++) begin
            fsel = gpb_alt_e'({cfg.alt_select_high[b], cfg.alt_select_low[b]});
            if (fsel != GPB_ALT_NONE) begin
                // peripheral owns direction; port direction bit ignored
                en  = alt_oe[b*3 + int'(fsel) - 1];
                val = alt_o[b*3 + int'(fsel) - 1];
            end else begin
                en  = ~cfg.dir[b];
                val = cfg.out_val[b];
            end
            next_drv_o[b]  = val;
            // open drain: a high is left to the pull-up
            next_drv_oe[b] = en & ~(val & cfg.odc[b]) & IMPL[b];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1  <= 8'h00;
            sync2  <= 8'h00;
            prev   <= 8'h00;
            fill   <= 2'h0;
            drv_o  <= 8'h00;
            drv_oe <= 8'h00;
        end else begin
            sync1  <= next_sync1;
            sync2  <= next_sync2;
            prev   <= next_prev;
            fill   <= next_fill;
            drv_o  <= next_drv_o;
            drv_oe <= next_drv_oe;
        end
    end

    assign pad_o     = drv_o;
    assign pad_oe    = drv_oe;
    assign cfg.level = sync2 & IMPL;
    assign alt_in    = sync2 & IMPL;
    // events held off until the synchroniser has real samples, else a
    // high pin would look like a rising edge just after reset
    assign cfg.evt   = (fill != `GPB_SYNC_FILL) ? 8'h00 :
                       EDGE_SEL ? (((rise & cfg.edge_rise) | (fall & ~cfg.edge_rise)) & IMPL)
                                : ((rise | fall) & IMPL);
endmodule

//--- tb/gpb_board.sv
// board side of the pads: external drivers and pull-ups
// assumes the bench sets ext_en and ext_val and drives the peripheral lines
`timescale 1ns/1ns
module gpb_board (
    input  wire logic [63:0] pad_o,
    input  wire logic [63:0] pad_oe,
    input  wire logic [63:0] ext_en,
    input  wire logic [63:0] ext_val,
    output      logic [63:0] pad_i
);
    // undriven pads float up, so an open-drain high still reads as one
    assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en);
endmodule

//--- tb/gpb_checker.sv
// checker on the gpio bank ports: bus handshake, reset, pins, synchroniser
// assumes it is bound onto gpb_top and shares its clock and reset
`timescale 1ns/1ns
module gpb_checker #(
    parameter logic [63:0] IMPL_MASK = 64'h0F02_02FF_FFFF_FFFF
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        wb_cyc,
    input wire logic        wb_stb,
    input wire logic        wb_ack,
    input wire logic [31:0] wb_dat_r,
    input wire logic        irq,
    input wire logic [63:0] pad_i,
    input wire logic [63:0] pad_o,
    input wire logic [63:0] pad_oe,
    input wire logic [63:0] alt_in
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_taken;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    sequence s_released;
        $fell(rst);
    endsequence
    AST_ACK_NEXT: assert property (s_taken |=> wb_ack) else $error("request not acknowledged");
    AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack |-> $past(wb_cyc) && $past(wb_stb) && !$past(wb_ack))
        else $error("ack without request");
    AST_RD_UPPER: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h00_0000) else $error("upper data set");
    AST_UNIMP_OE: assert property ((pad_oe & ~IMPL_MASK) == 64'h0) else $error("missing pin driven");
    AST_SYNC_TWO: assert property (!$past(rst) && !$past(rst, 2) |-> ((alt_in ^ $past(pad_i, 2)) & IMPL_MASK) == 64'h0)
        else $error("synchroniser delay wrong");
    AST_RST_PADS: assert property (s_released |-> pad_oe == 64'h0 && pad_o == 64'h0) else $error("pads not reset");
    AST_IRQ_QUIET: assert property (s_released |-> !irq [*3]) else $error("irq right after reset");
endmodule
bind gpb_top gpb_checker #(.IMPL_MASK(IMPL_MASK)) u_chk (.clk_sys(clk_sys), .rst(rst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .irq(irq), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe(pad_oe), .alt_in(alt_in));

//--- tb/gpb_top_tb.sv
// bench for the gpio bank: registers, drive, alternate select, interrupts
// assumes gpb_board on the pads and the bench acting as the peripherals
`timescale 1ns/1ns
`include "gpb_cfg.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected %0t got %h exp %h", $time, a, e); end end
module gpb_top_tb;
    import gpb_pkg::*;
    localparam logic [63:0] IMPL = `GPB_IMPL_MASK;
    logic          clk_sys  = 1'h0;
    logic          rst      = 1'h1;
    logic          wb_cyc   = 1'h0;
    logic          wb_stb   = 1'h0;
    logic          wb_we    = 1'h0;
    logic [31:0]   wb_adr   = 32'h0;
    logic [3:0]    wb_sel   = 4'h0;
    logic [31:0]   wb_dat_w = 32'h0;
    logic [31:0]   wb_dat_r;
    logic          wb_ack;
    logic          irq;
    logic [63:0]   pad_i;
    logic [63:0]   pad_o;
    logic [63:0]   pad_oe;
    logic [63:0]   alt_in;
    logic [63:0]   ext_en   = 64'h0;
    logic [63:0]   ext_val  = 64'h0;
    logic [191:0]  alt_o    = 192'h0;
    logic [191:0]  alt_oe   = 192'h0;
    logic [3:0]    sel_w    = 4'hF;
    int            error_cnt  = 0;
    int            n_compared = 0;
    int            cyc_cnt    = 0;

    gpb_top u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .irq(irq), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .alt_o(alt_o), .alt_oe(alt_oe),
        .alt_in(alt_in));
    gpb_board u_board (.pad_o(pad_o), .pad_oe(pad_oe), .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i));

    always #10 clk_sys = ~clk_sys;

    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic bus(input logic we, input logic [11:0] a, input gpb_byte_t d, output gpb_byte_t q);
        @(posedge clk_sys);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= 32'(a);
        wb_sel <= sel_w;
        wb_dat_w <= 32'(d);
        do @(posedge clk_sys); while (wb_ack !== 1'h1);
        q = wb_dat_r[7:0];
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
    endtask

    task automatic wr(input logic [11:0] a, input gpb_byte_t d);
        gpb_byte_t q;
        bus(1'h1, a, d, q);
    endtask

    task automatic rdc(input logic [11:0] a, input gpb_byte_t e);
        gpb_byte_t q;
        bus(1'h0, a, 8'h00, q);
        `CHK(q, e)
    endtask

    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        ext_en <= 64'hFFFF_FFFF_FFFF_FFFF;
        ext_val <= 64'hA55A_3CC3_0FF0_9669;
        for (int p = 0; p < 8; p++) begin
            rdc({3'(p), `GPB_OFS_OUT}, 8'h00);
            rdc({3'(p), `GPB_OFS_DIR}, 8'hFF);
            wr({3'(p), `GPB_OFS_OUT}, 8'hFF);
            rdc({3'(p), `GPB_OFS_OUT}, IMPL[8*p +: 8]);
            rdc({3'(p), `GPB_OFS_IN}, ext_val[8*p +: 8] & IMPL[8*p +: 8]);
            wr({3'(p), `GPB_OFS_IN}, ~ext_val[8*p +: 8]);
            rdc({3'(p), `GPB_OFS_IN}, ext_val[8*p +: 8] & IMPL[8*p +: 8]);
        end
        `CHK(pad_oe, 64'h0)
        wr({3'd1, `GPB_OFS_OUT}, 8'hA5);
        wr({3'd1, `GPB_OFS_DIR}, 8'h00);
        settle();
        `CHK(pad_oe[15:8], 8'hFF)
        `CHK(pad_o[15:8], 8'hA5)
        rdc({3'd1, `GPB_OFS_IN}, 8'hA5);
        wr({3'd1, `GPB_OFS_ODC}, 8'hFF);
        settle();
        `CHK(pad_oe[15:8], 8'h5A)
        wr({3'd1, `GPB_OFS_ODC}, 8'h00);
        wr({3'd1, `GPB_OFS_DIR}, 8'hF0);
        settle();
        `CHK(pad_oe[15:8], 8'h0F)
        // port d pin 0: fn1 drives 1, fn2 drives 0, fn3 releases
        alt_o[72 +: 3] <= 3'h5;
        alt_oe[72 +: 3] <= 3'h3;
        wr({3'd3, `GPB_OFS_DIR}, 8'hFE);
        for (int f = 0; f < 4; f++) begin
            wr({3'd3, `GPB_OFS_AFH}, 8'(f[1]));
            wr({3'd3, `GPB_OFS_AFL}, 8'(f[0]));
            settle();
            `CHK(pad_oe[24], f != 3)
            if (f < 3) `CHK(pad_o[24], 1'(4'h3 >> f))
        end
        wr({3'd0, `GPB_OFS_STAT}, 8'hFF);
        wr({3'd0, `GPB_OFS_EDGE}, 8'h02);
        wr({3'd0, `GPB_OFS_MASK}, 8'h02);
        ext_val[1] <= 1'h1;
        settle();
        `CHK(irq, 1'h1)
        rdc({3'd0, `GPB_OFS_STAT}, 8'h02);
        wr({3'd0, `GPB_OFS_STAT}, 8'h02);
        ext_val[1] <= 1'h0;
        settle();
        `CHK(irq, 1'h0)
        rdc({3'd0, `GPB_OFS_STAT}, 8'h00);
        // pin 0 keeps edge select 0, so only its falling edge counts
        wr({3'd0, `GPB_OFS_MASK}, 8'h01);
        ext_val[0] <= 1'h0;
        settle();
        `CHK(irq, 1'h1)
        rdc({3'd0, `GPB_OFS_STAT}, 8'h01);
        wr({3'd0, `GPB_OFS_STAT}, 8'h01);
        wr({3'd1, `GPB_OFS_STAT}, 8'hFF);
        wr({3'd1, `GPB_OFS_MASK}, 8'h10);
        ext_val[12] <= 1'h0;
        ext_val[13] <= 1'h1;
        settle();
        `CHK(irq, 1'h1)
        rdc({3'd1, `GPB_OFS_STAT}, 8'h30);
        wr({3'd1, `GPB_OFS_STAT}, 8'h30);
        settle();
        `CHK(irq, 1'h0)
        rdc(12'h200, 8'h00);
        rdc({3'd0, 6'h24}, 8'h00);
        // edge select only exists on ports with edge choice
        wr({3'd1, `GPB_OFS_EDGE}, 8'hFF);
        rdc({3'd1, `GPB_OFS_EDGE}, 8'h00);
        // low byte lane disabled: write acknowledged but dropped
        sel_w = 4'h0;
        wr({3'd4, `GPB_OFS_OUT}, 8'h55);
        sel_w = 4'hF;
        rdc({3'd4, `GPB_OFS_OUT}, 8'hFF);
        conclude();
    end
endmodule
